// File: hdl/acs_top.sv
/*
 Control logic of a 10-bit successive-approximation converter:
 APB registers, clock selection, acquisition and conversion sequencing.
 Assumes an analog front end driven by the sample, channel, reference
 and trial-code outputs, returning one comparator bit.
*/
// The APB slave port and the register addresses were chosen for this implementation.
// Functional notes
// - Format bit 7 set: right-justified result; clear: left-justified.
// - Acquisition code 111..000 gives 20,16,12,8,6,4,2,0 bit periods.
// - Clock code picks system clock /2,/8,/32,/4,/16,/64; x11 is RC.
// - RC clock: one instruction cycle delay before conversion clock starts.
// - Timing register bit 6 ignores writes, reads zero.
// - Reset returns registers to reset values, disabling and aborting.
// - Completion writes result pair, clears start bit, sets done flag.
// - Reset leaves result pair untouched.
// - Acquisition code 000: start ends sampling and converts at once.
// - Nonzero code: keep sampling programmed periods, then convert.
// - After each conversion sampling of selected channel resumes.
// - Start bit stays set through acquisition and conversion alike.
// - Each conversion takes exactly 11 bit periods.
// - At least 2 bit periods pass before next acquisition begins.
// - Sleeping conversions only run on the RC clock.
// - Sample capacitor disconnects when conversion begins; then SAR.
// - References selectable: supply rails or external reference pins.
// - Clearing start bit aborts; result pair keeps its last value.
// - Enable is control bit 0; start/status is bit 1.
// - Unimplemented channel codes convert to full scale.
`timescale 1ns/1ns
module acs_top (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    // APB slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic O_PREADY,
    output logic [31:0] O_PRDATA,
    output logic O_PSLVERR,
    // Analog front end
    input wire logic I_COMP,
    input wire logic I_RC_OSC,
    input wire logic I_SLEEP,
    output logic O_SAMPLE,
    output logic [3:0] O_CHANNEL,
    output logic [9:0] O_DAC_CODE,
    output logic O_VREFH_EXT,
    output logic O_VREFL_EXT,
    output logic [3:0] O_PIN_CFG,
    // Completion
    output logic O_CONV_IRQ
);
    import acs_pkg::*;

    typedef struct packed {
        logic en;
        logic go;
        logic [3:0] chan;
        logic [5:0] pinref;
        logic just;
        logic [2:0] acq_code;
        logic [2:0] clk_code;
        logic flag;
        logic irq_en;
        logic irq;
        logic [7:0] res_hi;
        logic [7:0] res_lo;
        acs_state_t st;
        logic [4:0] cnt;
        logic [9:0] sar;
        logic [9:0] dac;
        logic sample;
        logic [2:0][1:0] sync;
        logic [1:0] filt;
        logic ack;
        logic [31:0] prdata;
    } acs_regs_t;

    acs_regs_t st_ff;
    acs_regs_t nxt_st;

    logic tick;
    logic run;
    logic acc;
    logic mapped;
    logic wr;
    logic launch;
    logic done;
    logic [3:0] bidx;
    logic [9:0] sar_new;
    logic [9:0] res;
    logic [7:0] rd_byte;
    logic comp_f;
    logic rc_f;

    assign comp_f = st_ff.filt[0];
    assign rc_f = st_ff.filt[1];
    assign run = st_ff.st == ST_ACQ || st_ff.st == ST_CONV || st_ff.st == ST_HOLD;

    acs_tad_gen u_tad (
        .i_clk(I_CLK),
        .i_reset_n(I_RESET_N),
        .i_run(run),
        .i_sleep(I_SLEEP),
        .i_clk_code(st_ff.clk_code),
        .i_rc_level(rc_f),
        .o_tick(tick)
    );

    // Register decode and read mux
    always_comb begin
        mapped = 1'b1;
        rd_byte = 8'h00;
        if (I_PADDR == OFS_CTRL) begin
            rd_byte = {2'b00, st_ff.chan, st_ff.go, st_ff.en};
        end else if (I_PADDR == OFS_PINREF) begin
            rd_byte = {2'b00, st_ff.pinref};
        end else if (I_PADDR == OFS_TIMING) begin
            rd_byte = {st_ff.just, 1'b0, st_ff.acq_code, st_ff.clk_code};
        end else if (I_PADDR == OFS_RESH) begin
            rd_byte = st_ff.res_hi;
        end else if (I_PADDR == OFS_RESL) begin
            rd_byte = st_ff.res_lo;
        end else if (I_PADDR == OFS_IRQ) begin
            rd_byte = {6'h00, st_ff.irq_en, st_ff.flag};
        end else begin
            mapped = 1'b0;
        end
    end

    assign acc = I_PSEL & I_PENABLE;
    assign wr = acc & st_ff.ack & I_PWRITE & mapped;
    assign O_PREADY = st_ff.ack;
    assign O_PSLVERR = st_ff.ack & ~mapped;
    assign O_PRDATA = st_ff.prdata;

    always_comb begin
        nxt_st = st_ff;
        launch = 1'b0;
        done = 1'b0;
        bidx = 4'(CONV_LAST - st_ff.cnt);
        sar_new = st_ff.sar;
        res = st_ff.sar;

        // Three-stage input sync; a level counts once stages 2 and 3 agree
        nxt_st.sync[0] = {I_RC_OSC, I_COMP};
        nxt_st.sync[1] = st_ff.sync[0];
        nxt_st.sync[2] = st_ff.sync[1];
        for (int i = 0; i < 2; i++) begin
            if (st_ff.sync[1][i] == st_ff.sync[2][i]) begin
                nxt_st.filt[i] = st_ff.sync[2][i];
            end
        end

        // One wait state so read data leaves a flip-flop
        nxt_st.ack = acc & ~st_ff.ack;
        if (acc && !st_ff.ack) begin
            nxt_st.prdata = {24'h000000, rd_byte};
        end

        // Sequencer
        case (st_ff.st)
            ST_IDLE: begin
                if (st_ff.go) begin
                    if (is_rc(st_ff.clk_code)) begin
                        nxt_st.st = ST_RCDLY;
                        nxt_st.cnt = 5'h00;
                    end else begin
                        launch = 1'b1;
                    end
                end
            end
            ST_RCDLY: begin
                // One instruction cycle, counted in system clocks
                if (st_ff.cnt == 5'(RC_DLY_CYC - 5'h01)) begin
                    launch = 1'b1;
                end else begin
                    nxt_st.cnt = 5'(st_ff.cnt + 5'h01);
                end
            end
            ST_ACQ: begin
                if (tick) begin
                    if (st_ff.cnt == 5'(acq_tads(st_ff.acq_code) - 5'h01)) begin
                        nxt_st.st = ST_CONV;
                        nxt_st.cnt = 5'h00;
                        nxt_st.sar = 10'h000;
                        nxt_st.dac = 10'h000;
                    end else begin
                        nxt_st.cnt = 5'(st_ff.cnt + 5'h01);
                    end
                end
            end
            ST_CONV: begin
                if (tick) begin
                    nxt_st.cnt = 5'(st_ff.cnt + 5'h01);
                    if (st_ff.cnt == 5'h00) begin
                        // First period settles the held sample
                        nxt_st.dac = SAR_MSB;
                    end else begin
                        // Comparator high keeps the trial bit
                        sar_new[bidx] = comp_f;
                        nxt_st.sar = sar_new;
                        if (bidx != 4'h0) begin
                            nxt_st.dac = sar_new | 10'(10'h001 << (bidx - 4'h1));
                        end
                    end
                    if (st_ff.cnt == CONV_LAST) begin
                        done = 1'b1;
                    end
                end
            end
            ST_HOLD: begin
                if (tick) begin
                    if (st_ff.cnt == HOLDOFF_LAST) begin
                        nxt_st.st = ST_IDLE;
                    end else begin
                        nxt_st.cnt = 5'(st_ff.cnt + 5'h01);
                    end
                end
            end
            default: begin
                nxt_st.st = ST_IDLE;
            end
        endcase

        if (launch) begin
            nxt_st.cnt = 5'h00;
            if (st_ff.acq_code == CODE_RST) begin
                nxt_st.st = ST_CONV;
                nxt_st.sar = 10'h000;
                nxt_st.dac = 10'h000;
            end else begin
                nxt_st.st = ST_ACQ;
            end
        end

        if (done) begin
            if (st_ff.chan >= CH_IMPL) begin
                res = FULL_SCALE;
            end else begin
                res = sar_new;
            end
            if (st_ff.just) begin
                nxt_st.res_hi = {6'h00, res[9:8]};
                nxt_st.res_lo = res[7:0];
            end else begin
                nxt_st.res_hi = res[9:2];
                nxt_st.res_lo = {res[1:0], 6'h00};
            end
            nxt_st.go = 1'b0;
            nxt_st.st = ST_HOLD;
            nxt_st.cnt = 5'h00;
        end else if (!st_ff.go && st_ff.st != ST_IDLE && st_ff.st != ST_HOLD) begin
            // Abort leaves the result pair alone and still waits out the holdoff
            nxt_st.st = ST_HOLD;
            nxt_st.cnt = 5'h00;
        end

        // Software writes after the sequencer, so a set by software wins, except on the result pair, which completion keeps
        if (wr) begin
            if (I_PADDR == OFS_CTRL) begin
                nxt_st.en = I_PWDATA[CTRL_EN_BIT];
                // Start is only honoured while already enabled
                nxt_st.go = I_PWDATA[CTRL_GO_BIT] & st_ff.en;
                nxt_st.chan = I_PWDATA[CTRL_CH_LSB +: 4];
            end else if (I_PADDR == OFS_PINREF) begin
                nxt_st.pinref = I_PWDATA[PIN_CFG_LSB +: 6];
            end else if (I_PADDR == OFS_TIMING) begin
                nxt_st.just = I_PWDATA[TIM_JUST_BIT];
                nxt_st.acq_code = I_PWDATA[TIM_ACQ_LSB +: 3];
                nxt_st.clk_code = I_PWDATA[TIM_CLK_LSB +: 3];
            end else if (I_PADDR == OFS_RESH) begin
                if (!done) begin
                    nxt_st.res_hi = I_PWDATA[7:0];
                end
            end else if (I_PADDR == OFS_RESL) begin
                if (!done) begin
                    nxt_st.res_lo = I_PWDATA[7:0];
                end
            end else if (I_PADDR == OFS_IRQ) begin
                nxt_st.flag = I_PWDATA[IRQ_FLAG_BIT];
                nxt_st.irq_en = I_PWDATA[IRQ_EN_BIT];
            end
        end

        // Completion beats a clear in the same cycle
        if (done) begin
            nxt_st.flag = 1'b1;
        end

        // A disabled converter idles with no start pending
        if (!nxt_st.en) begin
            nxt_st.go = 1'b0;
            nxt_st.st = ST_IDLE;
        end

        nxt_st.irq = nxt_st.flag & nxt_st.irq_en;
        nxt_st.sample = nxt_st.en && (nxt_st.st == ST_IDLE
            || nxt_st.st == ST_RCDLY || nxt_st.st == ST_ACQ);
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            // Result pair deliberately holds through reset
            st_ff.en <= 1'b0;
            st_ff.go <= 1'b0;
            st_ff.chan <= CHAN_RST;
            st_ff.pinref <= PINREF_RST;
            st_ff.just <= 1'b0;
            st_ff.acq_code <= CODE_RST;
            st_ff.clk_code <= CODE_RST;
            st_ff.flag <= 1'b0;
            st_ff.irq_en <= 1'b0;
            st_ff.irq <= 1'b0;
            st_ff.st <= ST_IDLE;
            st_ff.cnt <= 5'h00;
            st_ff.sar <= 10'h000;
            st_ff.dac <= 10'h000;
            st_ff.sample <= 1'b0;
            st_ff.sync <= '0;
            st_ff.filt <= 2'h0;
            st_ff.ack <= 1'b0;
            st_ff.prdata <= 32'h00000000;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign O_SAMPLE = st_ff.sample;
    assign O_CHANNEL = st_ff.chan;
    assign O_DAC_CODE = st_ff.dac;
    assign O_VREFH_EXT = st_ff.pinref[PIN_VREFH_BIT];
    assign O_VREFL_EXT = st_ff.pinref[PIN_VREFL_BIT];
    assign O_PIN_CFG = st_ff.pinref[PIN_CFG_LSB +: 4];
    assign O_CONV_IRQ = st_ff.irq;
endmodule

// File: pkg/acs_pkg.sv
/*
 Constants, register map and state type of the converter sequencer.
 Assumes a 125 MHz system clock and a 32-bit APB register bus.
*/
package acs_pkg;
    localparam int unsigned SYS_CLK_HZ = 125_000_000;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PINREF = 8'h04;
    localparam logic [7:0] OFS_TIMING = 8'h08;
    localparam logic [7:0] OFS_RESH = 8'h0c;
    localparam logic [7:0] OFS_RESL = 8'h10;
    localparam logic [7:0] OFS_IRQ = 8'h14;

    // Field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_GO_BIT = 1;
    localparam int CTRL_CH_LSB = 2;
    localparam int PIN_CFG_LSB = 0;
    localparam int PIN_VREFH_BIT = 4;
    localparam int PIN_VREFL_BIT = 5;
    localparam int TIM_CLK_LSB = 0;
    localparam int TIM_ACQ_LSB = 3;
    localparam int TIM_JUST_BIT = 7;
    localparam int IRQ_FLAG_BIT = 0;
    localparam int IRQ_EN_BIT = 1;

    // Reset values
    localparam logic [3:0] CHAN_RST = 4'h0;
    localparam logic [5:0] PINREF_RST = 6'h00;
    localparam logic [2:0] CODE_RST = 3'h0;

    // Sequencing figures
    localparam logic [4:0] RC_DLY_CYC = 5'h04;
    localparam logic [4:0] CONV_LAST = 5'h0a;
    localparam logic [4:0] HOLDOFF_LAST = 5'h01;
    localparam logic [3:0] CH_IMPL = 4'hd;
    localparam logic [9:0] FULL_SCALE = 10'h3ff;
    localparam logic [9:0] SAR_MSB = 10'h200;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RCDLY,
        ST_ACQ,
        ST_CONV,
        ST_HOLD
    } acs_state_t;

    function automatic logic is_rc(input logic [2:0] code);
        return code[1:0] == 2'b11;
    endfunction

    // System clocks per converter bit period; zero for the RC clock
    function automatic logic [6:0] tad_div(input logic [2:0] code);
        case (code)
            3'h0: return 7'h02;
            3'h1: return 7'h08;
            3'h2: return 7'h20;
            3'h4: return 7'h04;
            3'h5: return 7'h10;
            3'h6: return 7'h40;
            default: return 7'h00;
        endcase
    endfunction

    // Automatic acquisition length in converter bit periods
    function automatic logic [4:0] acq_tads(input logic [2:0] code);
        case (code)
            3'h0: return 5'h00;
            3'h1: return 5'h02;
            3'h2: return 5'h04;
            3'h3: return 5'h06;
            3'h4: return 5'h08;
            3'h5: return 5'h0c;
            3'h6: return 5'h10;
            default: return 5'h14;
        endcase
    endfunction
endpackage

// File: hdl/acs_tad_gen.sv
/*
 Converter bit-period tick generator: divides the system clock or
 edge-detects the already synchronised RC oscillator level.
 Assumes i_rc_level is filtered in the system clock domain.
*/
`timescale 1ns/1ns
module acs_tad_gen (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Control
    input wire logic i_run,
    input wire logic i_sleep,
    input wire logic [2:0] i_clk_code,
    input wire logic i_rc_level,
    // Tick
    output logic o_tick
);
    import acs_pkg::*;

    typedef struct packed {
        logic [6:0] cnt;
        logic rc_prev;
    } acs_tg_t;

    acs_tg_t st_ff;
    acs_tg_t nxt_st;
    logic [6:0] last;

    always_comb begin
        nxt_st = st_ff;
        last = 7'(tad_div(i_clk_code) - 7'h01);
        nxt_st.rc_prev = i_rc_level;
        o_tick = 1'b0;
        if (!i_run) begin
            nxt_st.cnt = 7'h00;
        end else if (is_rc(i_clk_code)) begin
            // RC clock keeps running while the system sleeps
            o_tick = i_rc_level & ~st_ff.rc_prev;
        end else if (!i_sleep) begin
            // A stopped system clock in sleep halts the divider
            if (st_ff.cnt == last) begin
                o_tick = 1'b1;
                nxt_st.cnt = 7'h00;
            end else begin
                nxt_st.cnt = 7'(st_ff.cnt + 7'h01);
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule

// File: tb/acs_top_properties.sv
/*
 Port-level checker for the converter sequencer top.
 Assumes it is bound to acs_top and sees only its ports.
*/
`timescale 1ns/1ns
module acs_chk
    import acs_pkg::*;
(
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    // APB
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic O_PREADY,
    input wire logic [31:0] O_PRDATA,
    input wire logic O_PSLVERR,
    // Converter side
    input wire logic O_SAMPLE,
    input wire logic [9:0] O_DAC_CODE,
    input wire logic [3:0] O_PIN_CFG,
    input wire logic O_CONV_IRQ
);
    logic wr_acc;
    assign wr_acc = I_PSEL & I_PENABLE & I_PWRITE;
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);
    sequence s_conv_start;
        $fell(O_SAMPLE);
    endsequence
    property p_ready_wait;
        $rose(I_PENABLE) && I_PSEL |=> O_PREADY;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("ready missing");
    property p_ready_pulse;
        O_PREADY |=> !O_PREADY;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
    property p_unmapped;
        O_PSLVERR |-> O_PREADY && (I_PWRITE || O_PRDATA == 32'h0);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("bad error reply");
    property p_upper_zero;
        O_PREADY && !I_PWRITE |-> O_PRDATA[31:8] == 24'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
    property p_reset_state;
        $rose(I_RESET_N) |-> !O_SAMPLE && !O_CONV_IRQ && O_DAC_CODE == 10'h0 && O_PIN_CFG == 4'h0;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("not reset");
    property p_conv_min;
        s_conv_start |-> !O_SAMPLE [*8];
    endproperty
    a_conv_min: assert property (p_conv_min) else $error("conversion too short");
    property p_sar_begin;
        s_conv_start |-> ##[0:300] O_DAC_CODE == SAR_MSB;
    endproperty
    a_sar_begin: assert property (p_sar_begin) else $error("no first trial");
    property p_resume;
        s_conv_start |-> ##[8:1000] O_SAMPLE;
    endproperty
    a_resume: assert property (p_resume) else $error("sampling not resumed");
    property p_pin_cfg;
        $changed(O_PIN_CFG) |-> $past(wr_acc) || $past(wr_acc, 2);
    endproperty
    a_pin_cfg: assert property (p_pin_cfg) else $error("pin cfg moved");
endmodule

// File: tb/adc_acq_clock_sequencer_tb_top.sv
/*
 Self-checking bench for acs_top: table of conversions, then hand tests.
 Assumes the comparator settles within a few clocks of a trial code.
*/
`timescale 1ns/1ns
module adc_acq_clock_sequencer_tb_top;
    import acs_pkg::*;
    localparam int LIMIT = 20000;
    typedef struct {
        logic [2:0] ck, aq;
        logic j;
        logic [3:0] ch;
        logic [9:0] v, r;
        logic cv;
    } acs_row_t;
    logic clk, rst_n, psel, pen, pwr, pready, pslverr, comp, rc, slp, samp, vh, vl, irq, er;
    logic [7:0] paddr, eh, el;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] chan, pcfg;
    logic [9:0] dac, vin;
    int error_cnt, checked, cyc, t, d;
    // System clocks per bit period; RC edges come every 16
    int divs [8] = '{2, 8, 32, 16, 4, 16, 64, 16};
    int acqs [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    // Fast dividers see a stale comparator, so their values go unchecked
    acs_row_t rows [10] = '{
        '{3'h0, 3'h0, 1'h1, 4'h0, 10'h155, 10'h155, 1'h0},
        '{3'h4, 3'h1, 1'h0, 4'h1, 10'h0f0, 10'h0f0, 1'h0},
        '{3'h1, 3'h2, 1'h1, 4'h2, 10'h2aa, 10'h2aa, 1'h1},
        '{3'h5, 3'h3, 1'h0, 4'h3, 10'h3ff, 10'h3ff, 1'h1},
        '{3'h2, 3'h4, 1'h1, 4'hc, 10'h001, 10'h001, 1'h1},
        '{3'h6, 3'h0, 1'h0, 4'hd, 10'h123, 10'h3ff, 1'h1},
        '{3'h3, 3'h5, 1'h1, 4'h4, 10'h200, 10'h200, 1'h1},
        '{3'h7, 3'h0, 1'h0, 4'hf, 10'h000, 10'h3ff, 1'h1},
        '{3'h1, 3'h7, 1'h1, 4'h5, 10'h0ff, 10'h0ff, 1'h1},
        '{3'h1, 3'h6, 1'h0, 4'h8, 10'h301, 10'h301, 1'h1}};

    acs_top dut (.I_CLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready),
        .O_PRDATA(prdata), .O_PSLVERR(pslverr), .I_COMP(comp), .I_RC_OSC(rc),
        .I_SLEEP(slp), .O_SAMPLE(samp), .O_CHANNEL(chan), .O_DAC_CODE(dac),
        .O_VREFH_EXT(vh), .O_VREFL_EXT(vl), .O_PIN_CFG(pcfg), .O_CONV_IRQ(irq));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        comp <= (vin >= dac);
        rc <= cyc[3];
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            error_cnt++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        // Only the bench timeout ends a wait for the slave
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic wait_samp(input logic lvl, output int n);
        n = 0;
        while (samp !== lvl && n < 2000) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic conv(input acs_row_t r);
        int n, p;
        n = divs[r.ck];
        p = acqs[r.aq] * n;
        vin <= r.v;
        slp <= (r.ck[1:0] == 2'b11);
        apb(1'b1, OFS_TIMING, {24'h0, r.j, 1'b1, r.aq, r.ck});
        rchk(OFS_TIMING, {24'h0, r.j, 1'b0, r.aq, r.ck});
        apb(1'b1, OFS_IRQ, 32'h2);
        apb(1'b1, OFS_CTRL, {26'h0, r.ch, 2'b01});
        apb(1'b1, OFS_CTRL, {26'h0, r.ch, 2'b11});
        wait_samp(1'b0, t);
        wait_samp(1'b1, d);
        chk(32'(t > p - n && t <= p + n + 8), 32'h1);
        if (r.aq == 3'h0) chk(32'(r.ck[1:0] == 2'b11 ? t >= 5 : t <= 4), 32'h1);
        chk(32'(d > 12 * n && d <= 13 * n + 2), 32'h1);
        slp <= 1'b0;
        rchk(OFS_CTRL, {26'h0, r.ch, 2'b01});
        chk(chan, r.ch);
        rchk(OFS_IRQ, 32'h3);
        chk(irq, 1'b1);
        if (r.cv) begin
            eh = r.j ? {6'h0, r.r[9:8]} : r.r[9:2];
            el = r.j ? r.r[7:0] : {r.r[1:0], 6'h0};
            rchk(OFS_RESH, eh);
            rchk(OFS_RESL, el);
        end
    endtask

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        pen = 1'b0;
        pwr = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        slp = 1'b0;
        vin = 10'h0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rchk(OFS_CTRL, 32'h0);
        rchk(OFS_PINREF, 32'h0);
        rchk(OFS_TIMING, 32'h0);
        rchk(OFS_IRQ, 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        apb(1'b1, OFS_PINREF, 32'hff);
        rchk(OFS_PINREF, 32'h3f);
        chk({vl, vh, pcfg}, 6'h3f);
        $display("register tests done");
        foreach (rows[i]) begin
            conv(rows[i]);
            $display("row %0d done", i);
        end
        apb(1'b1, OFS_IRQ, 32'h1);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        rchk(OFS_IRQ, 32'h1);
        apb(1'b1, OFS_IRQ, 32'h0);
        rchk(OFS_IRQ, 32'h0);
        $display("mask test done");
        vin <= 10'h0aa;
        apb(1'b1, OFS_TIMING, 32'h01);
        apb(1'b1, OFS_CTRL, 32'h03);
        wait_samp(1'b0, t);
        repeat (40) @(posedge clk);
        rchk(OFS_CTRL, 32'h3);
        apb(1'b1, OFS_CTRL, 32'h1);
        wait_samp(1'b1, d);
        rchk(OFS_RESH, eh);
        rchk(OFS_RESL, el);
        rchk(OFS_IRQ, 32'h0);
        $display("abort test done");
        // Sleep with the system divider must freeze the conversion
        slp <= 1'b1;
        apb(1'b1, OFS_CTRL, 32'h03);
        wait_samp(1'b0, t);
        repeat (100) @(posedge clk);
        rchk(OFS_CTRL, 32'h3);
        chk(dac, 32'h0);
        slp <= 1'b0;
        wait_samp(1'b1, d);
        eh = 8'h2a;
        el = 8'h80;
        rchk(OFS_CTRL, 32'h1);
        rchk(OFS_RESH, eh);
        rchk(OFS_RESL, el);
        $display("sleep test done");
        apb(1'b1, OFS_CTRL, 32'h03);
        wait_samp(1'b0, t);
        repeat (20) @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rchk(OFS_CTRL, 32'h0);
        rchk(OFS_TIMING, 32'h0);
        rchk(OFS_RESH, eh);
        rchk(OFS_RESL, el);
        chk(samp, 1'b0);
        $display("reset test done");
        stop_test();
    end
endmodule

bind acs_top acs_chk u_chk (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .O_PREADY(O_PREADY), .O_PRDATA(O_PRDATA),
    .O_PSLVERR(O_PSLVERR), .O_SAMPLE(O_SAMPLE), .O_DAC_CODE(O_DAC_CODE),
    .O_PIN_CFG(O_PIN_CFG), .O_CONV_IRQ(O_CONV_IRQ));
